// ### core/flow_status.v
// Flow-control status register block with Avalon-MM slave and interrupt
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "flow_status_consts.vh"

// What this block does
// - Bits 7:6 report received Xoff/Xon characters
// - Received indications latch until host reads
// - Received field updates regardless of mode bits
// - Bits 5:4 report automatically sent flow characters
// - Sent field reads 00 without auto mode
// - Clearing auto mode enable clears sent field
// - Bits 3:2: 00 normal, 11 halted
// - Pending halt waits for current character end
// - Restart shows 10; host read returns 00
// - Bits 1:0 report output character state
// - Idle wait holds until a flow request arrives, data starts or a bit tick sees data queued
// - Pending flow character sent within one character
// - Host read clears bits 7:4
module flow_status (
	input wire core_clk,
	input wire sys_rst,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire rx_char_valid,
	input wire [7:0] rx_char,
	input wire [7:0] xon_pattern,
	input wire [7:0] xoff_pattern,
	input wire send_xoff_req,
	input wire send_xon_req,
	input wire flow_char_sent,
	input wire tx_char_busy,
	input wire tx_char_done,
	input wire tx_data_start,
	input wire transmit_queue_empty,
	input wire bit_tick,
	output wire tx_halt,
	output wire flow_char_req,
	output wire flow_char_is_xon,
	output wire irq
);

	// ----------------------------------------
	// Bus slave: one wait cycle per access
	// ----------------------------------------
	// The first cycle of a request takes a snapshot into the read data; the
	// second cycle releases waitrequest and applies read side effects.
	reg ack_q;
	reg [7:0] snap_q;
	wire req = avs_read | avs_write;
	wire accept = req & ack_q;
	wire rd_status = accept & avs_read & (avs_address == `ADDR_FLOW_STATUS);
	wire wr_lane0 = accept & avs_write & avs_byteenable[0];
	wire wr_ctrl = wr_lane0 & (avs_address == `ADDR_FLOW_CTRL);
	wire wr_clear = wr_lane0 & (avs_address == `ADDR_IRQ_CLEAR);
	wire wr_enable = wr_lane0 & (avs_address == `ADDR_IRQ_ENABLE);

	assign avs_waitrequest = req & ~ack_q;

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// Bit 0 mirrors the auto receiver flow enable, bit 1 the transmitter
	// flow control enable.
	reg [1:0] ctrl_q;
	wire auto_rx_en = ctrl_q[`CTRL_AUTO_RX_BIT];
	wire tx_flow_en = ctrl_q[`CTRL_TX_FLOW_BIT];

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= `FLOW_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= avs_writedata[1:0];
		end
	end

	// ----------------------------------------
	// Character recognition
	// ----------------------------------------
	// No mode or mask gating here, so the field doubles as a detector.
	wire xon_seen = rx_char_valid & (rx_char == xon_pattern);
	wire xoff_seen = rx_char_valid & (rx_char == xoff_pattern);

	// ----------------------------------------
	// Received and sent character fields
	// ----------------------------------------
	reg [1:0] rx_field_q;
	reg [1:0] sent_field_q;
	reg [1:0] txflow_q;
	reg [1:0] txchr_q;
	reg [1:0] rx_field_d;
	reg [1:0] sent_field_d;
	localparam [7:0] STATUS_RST = `FLOW_STATUS_RST;
	wire [7:0] status_word = {rx_field_q, sent_field_q, txflow_q, txchr_q};
	wire sent_xon = flow_char_sent & (txchr_q == `TXCHR_XON_PEND);
	wire sent_xoff = flow_char_sent & (txchr_q == `TXCHR_XOFF_PEND);

	always @* begin
		rx_field_d = rx_field_q;
		sent_field_d = sent_field_q;
		// Only bits that the host actually saw are cleared, so an event
		// landing between snapshot and accept survives.
		if (rd_status) begin
			rx_field_d = rx_field_d & ~snap_q[7:6];
			sent_field_d = sent_field_d & ~snap_q[5:4];
		end
		// Bit 6 is Xoff, bit 7 is Xon; both may accumulate.
		rx_field_d = rx_field_d | {xon_seen, xoff_seen};
		// Bit 4 is Xon sent, bit 5 is Xoff sent.
		sent_field_d = sent_field_d | {sent_xoff, sent_xon};
		if (!auto_rx_en) begin
			sent_field_d = 2'h0;
		end
	end

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_field_q <= STATUS_RST[7:6];
			sent_field_q <= 2'h0;
		end else begin
			rx_field_q <= rx_field_d;
			sent_field_q <= sent_field_d;
		end
	end

	// ----------------------------------------
	// Transmitter flow state
	// ----------------------------------------
	reg [1:0] txflow_d;

	always @* begin
		txflow_d = txflow_q;
		case (txflow_q)
		`TXFLOW_NORMAL, `TXFLOW_REENABLED: begin
			if (txflow_q == `TXFLOW_REENABLED && rd_status &&
					snap_q[3:2] == `TXFLOW_REENABLED) begin
				txflow_d = `TXFLOW_NORMAL;
			end
			if (tx_flow_en && xoff_seen) begin
				if (tx_char_busy) begin
					txflow_d = `TXFLOW_HALT_PEND;
				end else begin
					txflow_d = `TXFLOW_HALTED;
				end
			end
		end
		`TXFLOW_HALT_PEND: begin
			if (tx_flow_en && xon_seen) begin
				txflow_d = `TXFLOW_NORMAL;
			end else if (tx_char_done || !tx_char_busy) begin
				txflow_d = `TXFLOW_HALTED;
			end
		end
		`TXFLOW_HALTED: begin
			if (xon_seen || !tx_flow_en) begin
				txflow_d = `TXFLOW_REENABLED;
			end
		end
		default: begin
			txflow_d = `TXFLOW_NORMAL;
		end
		endcase
		if (!tx_flow_en && txflow_q != `TXFLOW_HALTED && txflow_d != `TXFLOW_REENABLED) begin
			txflow_d = `TXFLOW_NORMAL;
		end
	end

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txflow_q <= `TXFLOW_NORMAL;
		end else begin
			txflow_q <= txflow_d;
		end
	end

	// The transmitter must not start a new character while halted.
	assign tx_halt = (txflow_q == `TXFLOW_HALTED) |
		((txflow_q == `TXFLOW_HALT_PEND) & ~tx_char_busy);

	// ----------------------------------------
	// Output character state
	// ----------------------------------------
	// A pending flow character pre-empts queue data at the next character
	// boundary, which bounds the pending state to one character time.
	reg [1:0] txchr_d;
	reg idle_tick_q;
	reg idle_tick_d;

	always @* begin
		txchr_d = txchr_q;
		idle_tick_d = idle_tick_q;
		case (txchr_q)
		`TXCHR_NORMAL: begin
			if (send_xon_req) begin
				txchr_d = `TXCHR_XON_PEND;
			end else if (send_xoff_req) begin
				txchr_d = `TXCHR_XOFF_PEND;
			end
		end
		`TXCHR_XOFF_PEND, `TXCHR_XON_PEND: begin
			if (flow_char_sent) begin
				txchr_d = `TXCHR_IDLE_WAIT;
				idle_tick_d = 1'b0;
			end else if (send_xon_req) begin
				txchr_d = `TXCHR_XON_PEND;
			end else if (send_xoff_req) begin
				txchr_d = `TXCHR_XOFF_PEND;
			end
		end
		`TXCHR_IDLE_WAIT: begin
			if (send_xon_req) begin
				txchr_d = `TXCHR_XON_PEND;
			end else if (send_xoff_req) begin
				txchr_d = `TXCHR_XOFF_PEND;
			end else if (tx_data_start) begin
				txchr_d = `TXCHR_NORMAL;
			end else if (bit_tick && !transmit_queue_empty) begin
				// A bit tick has arrived with data waiting.
				txchr_d = `TXCHR_NORMAL;
			end else if (bit_tick) begin
				idle_tick_d = 1'b1;
			end
		end
		default: begin
			txchr_d = `TXCHR_NORMAL;
		end
		endcase
	end

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txchr_q <= `TXCHR_NORMAL;
			idle_tick_q <= 1'b0;
		end else begin
			txchr_q <= txchr_d;
			idle_tick_q <= idle_tick_d;
		end
	end

	assign flow_char_req = txchr_q[1];
	assign flow_char_is_xon = (txchr_q == `TXCHR_XON_PEND);

	// ----------------------------------------
	// Interrupt status, clear and enable
	// ----------------------------------------
	reg [4:0] irq_sts_q;
	reg [4:0] irq_en_q;
	wire [4:0] irq_set;

	assign irq_set[`IRQ_XOFF_RX] = xoff_seen;
	assign irq_set[`IRQ_XON_RX] = xon_seen;
	assign irq_set[`IRQ_HALTED] = (txflow_d == `TXFLOW_HALTED) &
		(txflow_q != `TXFLOW_HALTED);
	assign irq_set[`IRQ_REENABLED] = (txflow_d == `TXFLOW_REENABLED) &
		(txflow_q != `TXFLOW_REENABLED);
	assign irq_set[`IRQ_FLOW_SENT] = flow_char_sent & txchr_q[1];

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_sts_q <= `IRQ_RST;
			irq_en_q <= `IRQ_RST;
		end else begin
			// Set wins over a clear in the same cycle.
			if (wr_clear) begin
				irq_sts_q <= (irq_sts_q & ~avs_writedata[4:0]) | irq_set;
			end else begin
				irq_sts_q <= irq_sts_q | irq_set;
			end
			if (wr_enable) begin
				irq_en_q <= avs_writedata[4:0];
			end
		end
	end

	assign irq = |(irq_sts_q & irq_en_q);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Loaded in the wait cycle and held through the accepting edge.
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_readdata <= 32'h00000000;
			snap_q <= `FLOW_STATUS_RST;
		end else if (avs_read && !ack_q) begin
			snap_q <= 8'h00;
			case (avs_address)
			`ADDR_FLOW_STATUS: begin
				avs_readdata <= {24'h000000, status_word};
				snap_q <= status_word;
			end
			`ADDR_FLOW_CTRL: begin
				avs_readdata <= {30'h0000000, ctrl_q};
			end
			`ADDR_IRQ_STATUS: begin
				avs_readdata <= {27'h000000, irq_sts_q};
			end
			`ADDR_IRQ_ENABLE: begin
				avs_readdata <= {27'h000000, irq_en_q};
			end
			default: begin
				avs_readdata <= 32'h00000000;
			end
			endcase
		end
	end

endmodule

// ### core/flow_status_consts.vh
// Register offsets, field positions and codes of the flow-control status block
`ifndef FLOW_STATUS_CONSTS_VH
`define FLOW_STATUS_CONSTS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_FLOW_STATUS 8'h44
`define ADDR_FLOW_CTRL 8'h48
`define ADDR_IRQ_STATUS 8'h4C
`define ADDR_IRQ_CLEAR 8'h50
`define ADDR_IRQ_ENABLE 8'h54

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_AUTO_RX_BIT 0
`define CTRL_TX_FLOW_BIT 1
`define FLOW_STATUS_RST 8'h00
`define FLOW_CTRL_RST 2'h0
`define IRQ_RST 5'h00
`define IRQ_XOFF_RX 0
`define IRQ_XON_RX 1
`define IRQ_HALTED 2
`define IRQ_REENABLED 3
`define IRQ_FLOW_SENT 4

// ----------------------------------------
// Field codes
// ----------------------------------------
`define TXFLOW_NORMAL 2'h0
`define TXFLOW_HALT_PEND 2'h1
`define TXFLOW_REENABLED 2'h2
`define TXFLOW_HALTED 2'h3
`define TXCHR_NORMAL 2'h0
`define TXCHR_IDLE_WAIT 2'h1
`define TXCHR_XOFF_PEND 2'h2
`define TXCHR_XON_PEND 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`endif

// ### verification/flow_status_asserts.sv
// Port checks for the flow-control status block
`timescale 1ns/1ps
module flow_status_asserts (
	input wire core_clk,
	input wire sys_rst,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire rx_char_valid,
	input wire [7:0] rx_char,
	input wire [7:0] xon_pattern,
	input wire [7:0] xoff_pattern,
	input wire send_xoff_req,
	input wire send_xon_req,
	input wire flow_char_sent,
	input wire tx_char_done,
	input wire tx_halt,
	input wire flow_char_req,
	input wire flow_char_is_xon,
	input wire irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire xoff_m = rx_char_valid && rx_char == xoff_pattern;
	wire xon_m = rx_char_valid && rx_char == xon_pattern;
	// ----
	// Properties
	// ----
	wait_one_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read not accepted");
	xon_pend_a: assert property (send_xon_req |=> flow_char_req && flow_char_is_xon)
		else $error("xon not pending");
	xoff_pend_a: assert property (send_xoff_req |=> flow_char_req && !flow_char_is_xon)
		else $error("xoff not pending");
	pend_done_a: assert property (flow_char_sent && !send_xon_req && !send_xoff_req |=> !flow_char_req)
		else $error("pending kept after send");
	halt_cause_a: assert property ($rose(tx_halt) |-> $past(xoff_m) || tx_char_done)
		else $error("halt without cause");
	resume_cause_a: assert property ($fell(tx_halt) |-> $past(xon_m) || $past(avs_write, 2))
		else $error("resume without cause");
	irq_rise_a: assert property ($rose(irq) |-> $past(rx_char_valid || flow_char_sent || tx_char_done || avs_write))
		else $error("irq without event");
	irq_fall_a: assert property ($fell(irq) |-> $past(avs_write))
		else $error("irq dropped without write");
	cover property (tx_halt ##1 !tx_halt);
	cover property (flow_char_sent);
	cover property ($rose(irq));
endmodule
bind flow_status flow_status_asserts chk (.*);

// ### verification/remote_station.sv
// Remote station model: incoming characters and local line timing
`timescale 1ns/1ps
module remote_station #(parameter int CHAR_CYC = 40) (
	input wire core_clk,
	input wire flow_char_req,
	output logic rx_char_valid = 1'b0,
	output logic [7:0] rx_char = 8'h00,
	output logic flow_char_sent = 1'b0,
	output wire tx_char_busy,
	output logic tx_char_done = 1'b0,
	output logic bit_tick = 1'b0
);
	int cnt = 0;
	int ph = 0;
	logic flow = 1'b0;
	logic start = 1'b0;
	assign tx_char_busy = cnt > 0;
	// ----
	// Ten bit times of four clocks per character
	// ----
	always @(posedge core_clk) begin
		ph <= (ph + 1) % 4;
		bit_tick <= ph == 3;
		tx_char_done <= cnt == 1;
		flow_char_sent <= cnt == 1 && flow;
		if (cnt > 0) begin
			cnt <= cnt - 1;
		end else if ((flow_char_req && !flow_char_sent) || start) begin
			cnt <= CHAR_CYC;
			flow <= !start;
		end
	end
	// Line shows the inverse once the strobe is gone
	task rx(input [7:0] c);
		rx_char <= c;
		rx_char_valid <= 1'b1;
		@(posedge core_clk);
		rx_char_valid <= 1'b0;
		rx_char <= ~c;
	endtask
	task data_char;
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
	endtask
endmodule

// ### verification/tb_xon_xoff_flow_status.sv
// Testbench for the flow-control status block
`timescale 1ns/1ps
module tb_xon_xoff_flow_status;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	wire rx_char_valid;
	wire [7:0] rx_char;
	logic [7:0] xon_pattern = 8'h11;
	logic [7:0] xoff_pattern = 8'h13;
	logic send_xoff_req = 1'b0;
	logic send_xon_req = 1'b0;
	wire flow_char_sent;
	wire tx_char_busy;
	wire tx_char_done;
	logic tx_data_start = 1'b0;
	logic transmit_queue_empty = 1'b1;
	wire bit_tick;
	wire tx_halt;
	wire flow_char_req;
	wire flow_char_is_xon;
	wire irq;
	logic [31:0] rd_q;
	int errors = 0;
	int check_count = 0;
	flow_status uut (.*);
	remote_station peer (.*);
	always #50 core_clk = ~core_clk;
	// ----
	// Tasks
	// ----
	task chk(input string n, input [31:0] s, input [31:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task bus(input [7:0] a, input r, input [31:0] d);
		int k;
		avs_address <= a;
		avs_read <= r;
		avs_write <= !r;
		avs_writedata <= d;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		if (avs_waitrequest !== 1'b0) begin
			errors++;
			tally_and_finish;
		end
		rd_q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask
	task rd(input [7:0] a, input [31:0] e);
		bus(a, 1'b1, 32'h0);
		chk($sformatf("reg %h", a), rd_q, e);
	endtask
	task wr(input [7:0] a, input [31:0] d);
		bus(a, 1'b0, d);
	endtask
	task req(input x);
		send_xon_req <= x;
		send_xoff_req <= !x;
		@(posedge core_clk);
		send_xon_req <= 1'b0;
		send_xoff_req <= 1'b0;
	endtask
	// Bounded wait until the line is quiet again
	task settle;
		int k;
		@(posedge core_clk);
		for (k = 0; k < 200 && (flow_char_req | tx_char_busy) !== 1'b0; k++) @(posedge core_clk);
		@(posedge core_clk);
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		rd(8'h44, 32'h00);
		wr(8'h60, 32'hFF);
		rd(8'h60, 32'h00);
		$display("reset test done");
		peer.rx(8'h13);
		rd(8'h44, 32'h40);
		rd(8'h44, 32'h00);
		peer.rx(8'h13);
		peer.rx(8'h11);
		peer.rx(8'h41);
		rd(8'h44, 32'hC0);
		xon_pattern <= 8'h41;
		peer.rx(8'h11);
		rd(8'h44, 32'h00);
		peer.rx(8'h41);
		rd(8'h44, 32'h80);
		xon_pattern <= 8'h11;
		$display("receive test done");
		req(1'b0);
		rd(8'h44, 32'h02);
		settle;
		rd(8'h44, 32'h01);
		wr(8'h48, 32'h01);
		req(1'b1);
		rd(8'h44, 32'h03);
		settle;
		rd(8'h44, 32'h11);
		req(1'b0);
		settle;
		req(1'b1);
		settle;
		rd(8'h44, 32'h31);
		req(1'b0);
		settle;
		wr(8'h48, 32'h00);
		rd(8'h44, 32'h01);
		req(1'b1);
		settle;
		transmit_queue_empty <= 1'b0;
		repeat (5) @(posedge core_clk);
		rd(8'h44, 32'h00);
		transmit_queue_empty <= 1'b1;
		req(1'b0);
		settle;
		rd(8'h44, 32'h01);
		tx_data_start <= 1'b1;
		@(posedge core_clk);
		tx_data_start <= 1'b0;
		rd(8'h44, 32'h00);
		$display("send test done");
		wr(8'h48, 32'h02);
		avs_byteenable <= 4'hE;
		wr(8'h48, 32'h00);
		avs_byteenable <= 4'hF;
		rd(8'h48, 32'h02);
		peer.data_char;
		peer.rx(8'h13);
		rd(8'h44, 32'h44);
		settle;
		rd(8'h44, 32'h0C);
		chk("tx_halt", {31'h0, tx_halt}, 32'h1);
		peer.rx(8'h11);
		rd(8'h44, 32'h88);
		rd(8'h44, 32'h00);
		$display("flow test done");
		wr(8'h4C, 32'h00);
		wr(8'h54, 32'h1F);
		rd(8'h4C, 32'h1F);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(8'h54, 32'h00);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(8'h50, 32'h1F);
		rd(8'h4C, 32'h00);
		wr(8'h54, 32'h1F);
		peer.rx(8'h13);
		rd(8'h4C, 32'h05);
		chk("irq", {31'h0, irq}, 32'h1);
		$display("interrupt test done");
		tally_and_finish;
	end
	initial begin
		#(100 * 5000);
		errors++;
		tally_and_finish;
	end
endmodule
